/* hdl/tgc_gate_control.sv */
// timer gate control block with wishbone registers and gate event interrupt
`timescale 1ns/10ps
module tgc_gate_control (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [3:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire tgc_pkg::tgc_gate_in_type gate_in_i,
  output logic                          count_enable_o,
  output logic                          timer_on_o,
  output logic                          irq_o
);
  // register state
  tgc_pkg::tgc_gate_ctrl_type gate_ctrl;
  tgc_pkg::tgc_gate_ctrl_type next_gate_ctrl;
  logic [7:0]  timer_ctrl;
  logic [7:0]  next_timer_ctrl;
  logic [7:0]  irq_status;
  logic [7:0]  next_irq_status;
  logic [7:0]  irq_mask;
  logic [7:0]  next_irq_mask;
  logic [31:0] next_wb_dat;
  logic        next_wb_ack;
  // synchroniser and gate path state
  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  sync3;
  logic [3:0]  filt;
  logic [3:0]  next_filt;
  logic        src_prev;
  logic        toggle_ff;
  logic        next_toggle_ff;
  logic        spm_armed;
  logic        next_spm_armed;
  logic        spm_gate;
  logic        next_spm_gate;
  logic        level_prev;
  logic        count_en;
  logic        next_count_en;
  logic        irq_q;
  logic        next_irq_q;
  // combinational gate path
  logic [3:0]  raw_in;
  logic        src_sel;
  logic        src_pol;
  logic        pol_prev;
  logic        pol_rise;
  logic        gate_level;
  logic        level_fall;
  logic        wr_stb;
  logic        rd_stb;
  logic        cmp_sync;

  // raw inputs, bus strobes taken while ack is low, comparator path choice
  assign raw_in = {gate_in_i.gate_pin, gate_in_i.timer0_overflow,
                   gate_in_i.cmp1_out, gate_in_i.cmp2_out};
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cmp_sync = ~timer_ctrl[tgc_pkg::TC_SYNC_BIT];

  // three-stage input capture, change accepted when stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end
    else
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // glitch filter on the captured inputs
  always_comb
  begin
    next_filt = filt;
    for (int i = 0; i < 4; i++)
    begin
      if (sync2[i] == sync3[i])
      begin
        next_filt[i] = sync3[i];
      end
    end
  end

  // source select, comparators may bypass the final filter stage
  always_comb
  begin
    case (gate_ctrl.gate_source_select)
      tgc_pkg::TGC_SRC_PIN:  src_sel = filt[3];
      tgc_pkg::TGC_SRC_OVF:  src_sel = filt[2];
      tgc_pkg::TGC_SRC_CMP1: src_sel = cmp_sync ? filt[1] : sync3[1];
      tgc_pkg::TGC_SRC_CMP2: src_sel = cmp_sync ? filt[0] : sync3[0];
      default:               src_sel = filt[3];
    endcase
  end

  // polarity of the chosen source and its active-going edge
  always_comb
  begin
    src_pol = gate_ctrl.gate_polarity ? src_sel : ~src_sel;
    pol_prev = gate_ctrl.gate_polarity ? src_prev : ~src_prev;
    pol_rise = src_pol & ~pol_prev;
  end

  // toggle flip-flop, flips on the active edge so polarity still applies
  always_comb
  begin
    next_toggle_ff = toggle_ff;
    if (!gate_ctrl.gate_toggle_mode)
    begin
      next_toggle_ff = 1'b0;
    end
    else if (pol_rise)
    begin
      next_toggle_ff = ~toggle_ff;
    end
  end

  // single-pulse window, opens on the first active edge after go
  always_comb
  begin
    next_spm_armed = 1'b0;
    next_spm_gate = 1'b0;
    if (gate_ctrl.single_pulse_mode && gate_ctrl.pulse_acquire_go)
    begin
      next_spm_armed = 1'b1;
      next_spm_gate = spm_gate | (spm_armed & pol_rise);
    end
  end

  // effective gate level and count qualification
  always_comb
  begin
    if (gate_ctrl.single_pulse_mode)
    begin
      gate_level = spm_gate & (gate_ctrl.gate_toggle_mode ? toggle_ff : src_pol);
    end
    else
    begin
      gate_level = gate_ctrl.gate_toggle_mode ? toggle_ff : src_pol;
    end
    level_fall = level_prev & ~gate_level;
    // count qualification
    if (!timer_ctrl[tgc_pkg::TC_ON_BIT])
    begin
      next_count_en = 1'b0;
    end
    else if (gate_ctrl.gate_enable_bit)
    begin
      next_count_en = gate_level;
    end
    else
    begin
      next_count_en = 1'b1;
    end
  end

  // gate path registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      filt       <= 4'h0;
      src_prev   <= 1'b0;
      toggle_ff  <= 1'b0;
      spm_armed  <= 1'b0;
      spm_gate   <= 1'b0;
      level_prev <= 1'b0;
      count_en   <= 1'b0;
    end
    else
    begin
      filt       <= next_filt;
      src_prev   <= src_sel;
      toggle_ff  <= next_toggle_ff;
      spm_armed  <= next_spm_armed;
      spm_gate   <= next_spm_gate;
      level_prev <= gate_level;
      count_en   <= next_count_en;
    end
  end

  // register writes, hardware clear of go and event flag set
  always_comb
  begin
    next_gate_ctrl = gate_ctrl;
    next_timer_ctrl = timer_ctrl;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (wr_stb)
    begin
      case (wb_adr_i)
        tgc_pkg::ADDR_TIMER_CONTROL:
          next_timer_ctrl = wb_dat_i[7:0] & tgc_pkg::TC_WRITE_MASK;
        tgc_pkg::ADDR_GATE_CONTROL:
          next_gate_ctrl = tgc_pkg::tgc_gate_ctrl_type'(wb_dat_i[7:0]);
        tgc_pkg::ADDR_IRQ_STATUS:
          next_irq_status = irq_status & ~wb_dat_i[7:0];
        tgc_pkg::ADDR_IRQ_MASK:
          next_irq_mask = wb_dat_i[7:0];
        default:
          next_irq_mask = irq_mask;
      endcase
    end
    next_gate_ctrl.gate_level_now = gate_level;
    // once armed, go is cleared by hardware or by a write that clears single pulse mode
    if (wr_stb && wb_adr_i == tgc_pkg::ADDR_GATE_CONTROL && gate_ctrl.pulse_acquire_go &&
        !wb_dat_i[tgc_pkg::GC_GO_BIT] && next_gate_ctrl.single_pulse_mode)
    begin
      next_gate_ctrl.pulse_acquire_go = 1'b1;
    end
    if (gate_ctrl.single_pulse_mode && spm_gate && level_fall)
    begin
      next_gate_ctrl.pulse_acquire_go = 1'b0;
    end
    // a fall in the clear cycle still sets the flag
    if (level_fall)
    begin
      next_irq_status[tgc_pkg::IRQ_GATE_BIT] = 1'b1;
    end
    next_irq_q = |(next_irq_status & next_irq_mask);
  end

  // bus read mux and single-cycle acknowledge
  always_comb
  begin
    next_wb_ack = rd_stb;
    next_wb_dat = 32'h0000_0000;
    case (wb_adr_i)
      tgc_pkg::ADDR_TIMER_CONTROL: next_wb_dat = {24'h00_0000, timer_ctrl};
      tgc_pkg::ADDR_GATE_CONTROL:  next_wb_dat = {24'h00_0000, gate_ctrl};
      tgc_pkg::ADDR_IRQ_STATUS:    next_wb_dat = {24'h00_0000, irq_status};
      tgc_pkg::ADDR_IRQ_MASK:      next_wb_dat = {24'h00_0000, irq_mask};
      default:                     next_wb_dat = 32'h0000_0000;
    endcase
  end

  // register file and bus outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate_ctrl  <= tgc_pkg::tgc_gate_ctrl_type'(tgc_pkg::GATE_CONTROL_RESET);
      timer_ctrl <= tgc_pkg::TIMER_CONTROL_RESET;
      irq_status <= tgc_pkg::IRQ_STATUS_RESET;
      irq_mask   <= tgc_pkg::IRQ_MASK_RESET;
      irq_q      <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end
    else
    begin
      gate_ctrl  <= next_gate_ctrl;
      timer_ctrl <= next_timer_ctrl;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq_q      <= next_irq_q;
      wb_ack_o   <= next_wb_ack;
      wb_dat_o   <= next_wb_dat;
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_on_o <= 1'b0;
    end
    else
    begin
      timer_on_o <= next_timer_ctrl[tgc_pkg::TC_ON_BIT];
    end
  end
  // registered gate and interrupt outputs
  assign count_enable_o = count_en;
  assign irq_o = irq_q;
endmodule

/* hdl/tgc_pkg.sv */
// package for the timer gate control block: offsets, fields, resets, types
package tgc_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_GATE_CONTROL  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS    = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK      = 4'hc;
  // gate control field positions
  localparam int GC_ENABLE_BIT   = 7;
  localparam int GC_POLARITY_BIT = 6;
  localparam int GC_TOGGLE_BIT   = 5;
  localparam int GC_SINGLE_BIT   = 4;
  localparam int GC_GO_BIT       = 3;
  localparam int GC_LEVEL_BIT    = 2;
  localparam int GC_SRC_LSB      = 0;
  // timer control field positions
  localparam int TC_ON_BIT       = 0;
  localparam int TC_SYNC_BIT     = 2;
  // interrupt status field position
  localparam int IRQ_GATE_BIT    = 0;
  // reset values
  localparam logic [7:0] GATE_CONTROL_RESET  = 8'h00;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET      = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RESET    = 8'h00;
  // timer control bits kept as storage, bit 1 reads as zero
  localparam logic [7:0] TC_WRITE_MASK       = 8'hfd;

  // gate source select codes
  typedef enum logic [1:0] {
    TGC_SRC_PIN   = 2'b00,
    TGC_SRC_OVF   = 2'b01,
    TGC_SRC_CMP1  = 2'b10,
    TGC_SRC_CMP2  = 2'b11
  } tgc_src_type;

  // gate control register layout
  typedef struct packed {
    logic        gate_enable_bit;
    logic        gate_polarity;
    logic        gate_toggle_mode;
    logic        single_pulse_mode;
    logic        pulse_acquire_go;
    logic        gate_level_now;
    tgc_src_type gate_source_select;
  } tgc_gate_ctrl_type;

  // raw gate inputs from the rest of the chip
  typedef struct packed {
    logic gate_pin;
    logic timer0_overflow;
    logic cmp1_out;
    logic cmp2_out;
  } tgc_gate_in_type;
endpackage

/* sim/tb.sv */
// self-checking bench for the timer gate control block
`timescale 1ns/10ps
module tb;
  typedef struct packed
  {
    logic [7:0] tc;
    logic [7:0] gc;
    logic [3:0] gin;
    logic       ce;
    logic       lvl;
  } tgc_row_type;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h1;
  logic [31:0] dat = 32'h0;
  logic [3:0]  gin = 4'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        ce;
  logic        ton;
  logic        irq;
  logic [7:0]  rd;
  int          error_cnt = 0;
  int          tests_run = 0;
  // timer control, gate control, {pin,ovf,cmp1,cmp2}, count, level
  tgc_row_type rows [14] = '{
    '{8'h01, 8'h00, 4'h0, 1'h1, 1'h1},
    '{8'h01, 8'h80, 4'h0, 1'h1, 1'h1},
    '{8'h01, 8'h80, 4'h8, 1'h0, 1'h0},
    '{8'h01, 8'hc0, 4'h8, 1'h1, 1'h1},
    '{8'h01, 8'hc0, 4'h0, 1'h0, 1'h0},
    '{8'h00, 8'hc0, 4'h8, 1'h0, 1'h1},
    '{8'h01, 8'h40, 4'h8, 1'h1, 1'h1},
    '{8'h01, 8'h40, 4'h0, 1'h1, 1'h0},
    '{8'h01, 8'hc1, 4'h4, 1'h1, 1'h1},
    '{8'h01, 8'hc1, 4'h8, 1'h0, 1'h0},
    '{8'h01, 8'hc2, 4'h2, 1'h1, 1'h1},
    '{8'h01, 8'hc3, 4'h1, 1'h1, 1'h1},
    '{8'h01, 8'hc3, 4'h2, 1'h0, 1'h0},
    '{8'h05, 8'hc2, 4'h2, 1'h1, 1'h1}};
  always #20 clk_i = ~clk_i;
  tgc_gate_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .gate_in_i(tgc_pkg::tgc_gate_in_type'(gin)), .count_enable_o(ce),
    .timer_on_o(ton), .irq_o(irq));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic wishbone cycle, read byte lands in rd
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
      error_cnt++;
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic settle;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial
  begin
    repeat (6000) @(posedge clk_i);
    error_cnt++;
    final_report;
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a += 4)
    begin
      wb(1'b0, 4'(a), 8'h00);
      chk("reset_value", rd, (a == 4) ? 8'h04 : 8'h00);
    end
    foreach (rows[i])
    begin
      wb(1'b1, 4'h0, rows[i].tc);
      wb(1'b1, 4'h4, rows[i].gc);
      gin <= rows[i].gin;
      settle;
      chk("count_enable", 8'(ce), 8'(rows[i].ce));
      wb(1'b0, 4'h4, 8'h00);
      chk("gate_readback", rd, {rows[i].gc[7:3], rows[i].lvl, rows[i].gc[1:0]});
    end
    wb(1'b1, 4'h0, 8'hff);
    wb(1'b0, 4'h0, 8'h00);
    chk("timer_control", rd, tgc_pkg::TC_WRITE_MASK);
    wb(1'b1, 4'h0, 8'h01);
    chk("timer_on", 8'(ton), 8'h01);
    // toggle flop flips on a pin rise and clears with the mode bit
    gin <= 4'h0;
    wb(1'b1, 4'h4, 8'he0);
    gin <= 4'h8;
    settle;
    gin <= 4'h0;
    settle;
    chk("toggle_on", 8'(ce), 8'h01);
    wb(1'b1, 4'h4, 8'hc0);
    wb(1'b1, 4'h4, 8'he0);
    settle;
    chk("toggle_cleared", 8'(ce), 8'h00);
    // single pulse acquisition with unmasked event
    wb(1'b1, 4'h8, 8'h01);
    wb(1'b1, 4'hc, 8'h01);
    wb(1'b1, 4'h4, 8'hd8);
    wb(1'b1, 4'h4, 8'hd0);
    wb(1'b0, 4'h4, 8'h00);
    chk("go_armed", rd, 8'hd8);
    gin <= 4'h8;
    settle;
    chk("pulse_open", 8'(ce), 8'h01);
    wb(1'b0, 4'h4, 8'h00);
    chk("go_held", rd, 8'hdc);
    gin <= 4'h0;
    settle;
    wb(1'b0, 4'h4, 8'h00);
    chk("go_done", rd, 8'hd0);
    chk("irq_set", 8'(irq), 8'h01);
    wb(1'b1, 4'h8, 8'h01);
    chk("irq_clear", 8'(irq), 8'h00);
    // masked event stays pending until unmasked
    wb(1'b1, 4'hc, 8'h00);
    wb(1'b1, 4'h4, 8'hc0);
    gin <= 4'h8;
    settle;
    gin <= 4'h0;
    settle;
    chk("irq_masked", 8'(irq), 8'h00);
    wb(1'b0, 4'h8, 8'h00);
    chk("flag_pending", rd, 8'h01);
    wb(1'b1, 4'hc, 8'h01);
    chk("irq_unmask", 8'(irq), 8'h01);
    // reset in mid-run
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("reset_outputs", {5'h0, ce, ton, irq}, 8'h00);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 8'h00);
    chk("reset_timer", rd, 8'h00);
    final_report;
  end
endmodule

/* sim/tgc_gate_control_assertions.sv */
// port checker for the timer gate control block
`timescale 1ns/10ps
module tgc_gate_control_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        count_enable_o,
  input wire logic        timer_on_o,
  input wire logic        irq_o
);
  logic gc_en;
  logic msk;
  logic wr_ok;
  logic wr_take;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign wr_ok = wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i[0];
  // write taken on the same edge as the register file
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // shadows of gate enable and irq mask, in step with the registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gc_en <= 1'b0;
      msk   <= 1'b0;
    end
    else if (wr_take && wb_adr_i == tgc_pkg::ADDR_GATE_CONTROL)
      gc_en <= wb_dat_i[tgc_pkg::GC_ENABLE_BIT];
    else if (wr_take && wb_adr_i == tgc_pkg::ADDR_IRQ_MASK)
      msk <= wb_dat_i[0];
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_answers: assert property (s_req |=> s_pulse)
    else $error("ack not a one cycle answer");
  a_ack_caused: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack outside cycle");
  a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read upper bits not zero");
  a_off_no_count: assert property (!timer_on_o [*2] |-> !count_enable_o)
    else $error("count while timer off");
  a_free_count: assert property ((timer_on_o && !gc_en) [*4] |-> count_enable_o)
    else $error("no count with gate disabled");
  a_mask_blocks: assert property (!msk [*2] |-> !irq_o)
    else $error("irq while masked");
  a_on_follows: assert property (wr_ok && wb_adr_i == tgc_pkg::ADDR_TIMER_CONTROL
    |-> timer_on_o == wb_dat_i[0])
    else $error("timer on not written");
endmodule
bind tgc_gate_control tgc_gate_control_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .count_enable_o(count_enable_o), .timer_on_o(timer_on_o), .irq_o(irq_o));
